// ==== inc/ssc_map.svh ====
// Offsets, field positions, reset values and timing counts of the serial configuration bank.
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

`define SSC_WORD_W        32
`define SSC_SEL_W         3
`define SSC_SEL_R0        3'h0
`define SSC_SEL_R1        3'h1
`define SSC_SEL_R2        3'h2
`define SSC_SEL_R3        3'h3
`define SSC_SEL_R4        3'h4
`define SSC_SEL_R5        3'h5
`define SSC_SEL_R6        3'h6
`define SSC_SEL_R7        3'h7
`define SSC_R0_RAMP_ON    31
`define SSC_R0_MON_HI     30
`define SSC_R0_MON_LO     27
`define SSC_R0_INT_HI     26
`define SSC_R0_INT_LO     15
`define SSC_R0_FMSB_HI    14
`define SSC_R0_FMSB_LO    3
`define SSC_R1_PH_EN      28
`define SSC_R1_FLSB_HI    27
`define SSC_R1_FLSB_LO    15
`define SSC_R1_PH_HI      14
`define SSC_R1_PH_LO      3
`define SSC_FLSB_W        13
`define SSC_R3_MUST_ONE   32'h0002_0000
`define SSC_WORD_RESET    32'h0000_0000
`define SSC_HOST_DIV      4

`endif

// ==== inc/ssc_pkg.sv ====
// Types shared by both ends of the serial configuration link.
package ssc_pkg;
  typedef logic [31:0] ssc_word_t;
  typedef logic [2:0]  ssc_sel_t;
  typedef enum logic [1:0] {SSC_IDLE, SSC_SHIFT, SSC_LOAD} ssc_host_e;
endpackage

// ==== inc/ssc_link_if.sv ====
// Three-wire serial programming link between host and synthesizer bank.
`timescale 1ns/1ps
interface ssc_link_if;
  logic ser_clk;
  logic ser_data;
  logic load_strobe;
  modport host (output ser_clk, output ser_data, output load_strobe);
  modport device (input ser_clk, input ser_data, input load_strobe);
endinterface

// ==== core/ssc_host.sv ====
// Host end: shifts one 32-bit word out MSB first, then pulses the load strobe.
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_host
  import ssc_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      nrst_i,
  input  wire logic      clk_en_i,
  input  wire logic      req_i,
  input  wire ssc_word_t word_i,
  output logic           busy_o,
  output logic           done_o,
  ssc_link_if.host       link
);
  typedef struct packed {
    ssc_host_e state;
    ssc_word_t sh;
    logic [5:0] bits;
    logic [7:0] div;
    logic       sclk;
    logic       le;
    logic       busy;
    logic       done;
  } ssc_hst_s;

  ssc_hst_s r, next_r;

  // Divider half period; the link clock is made here, not received.
  localparam logic [7:0] HALF = 8'(`SSC_HOST_DIV - 1);

  // Data changes on the falling link edge so the device samples it stable on the rising one.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    unique case (r.state)
      SSC_IDLE: begin
        if (req_i) begin
          next_r.sh    = word_i;
          next_r.bits  = 6'h00;
          next_r.div   = 8'h00;
          next_r.busy  = 1'b1;
          next_r.state = SSC_SHIFT;
        end
      end
      SSC_SHIFT: begin
        if (r.div == HALF) begin
          next_r.div  = 8'h00;
          next_r.sclk = ~r.sclk;
          if (r.sclk) begin // Falling edge: next MSB out.
            next_r.sh = {r.sh[30:0], 1'b0};
            if (r.bits == 6'h1f) begin
              next_r.state = SSC_LOAD;
              next_r.sclk  = 1'b0;
            end
            next_r.bits = 6'(r.bits + 6'h01);
          end
        end else begin
          next_r.div = 8'(r.div + 8'h01);
        end
      end
      SSC_LOAD: begin
        // Strobe rises after the last edge and is held one half period.
        next_r.le = 1'b1;
        if (r.le) begin
          if (r.div == HALF) begin
            next_r.le    = 1'b0;
            next_r.busy  = 1'b0;
            next_r.done  = 1'b1;
            next_r.state = SSC_IDLE;
          end else begin
            next_r.div = 8'(r.div + 8'h01);
          end
        end else begin
          next_r.div = 8'h00;
        end
      end
    endcase
  end

  // Whole host state in one register, frozen when the enable is low.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  assign link.ser_clk     = r.sclk;
  assign link.ser_data    = r.sh[31];
  assign link.load_strobe = r.le;
  assign busy_o           = r.busy;
  assign done_o           = r.done;
endmodule

// ==== core/ssc_dev.sv ====
// Device end: serial input shift register, eight latches, and double-buffered commit.
//
// Summary of operation
// - Shift MSB first; latch on strobe rise.
// - Low three bits pick latch 0..7.
// - Staged settings apply after register 0 write.
// - Select 000 loads main divider word.
// - Register 0 bit 31 enables ramp.
// - Register 0 bits 30:27 pick monitor output.
// - Register 0 bits 26:15 hold integer.
// - Fraction: 12 high in r0, 13 low r1.
// - Fraction = low plus high times 8192.
// - Select 001 loads fraction low, phase word.
// - Host writes zero in r1 bits 31:29.
// - Phase applied only when r1 bit 28 set.
// - Phase word r1 bits 14:3, 4096 steps.
// - Phase change waits for register 0 write.
// - Host sets phase zero when unused.
// - Select 010 loads reference divider word.
// - Register 3 function bits; bit 17 one.
// - Register 5 deviation fields, others zero.
// - Register 6 step word and select.
// - Register 7 delayed start and ramp flags.
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_dev
  import ssc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        clk_en_i,
  ssc_link_if.device       link,
  output logic             ramp_on_o,
  output logic [3:0]       output_monitor_select_o,
  output logic [11:0]      int_value_o,
  output logic [24:0]      subunit_numerator_o,
  output logic             phase_adjust_on_o,
  output logic [11:0]      phase_word_o,
  output logic             phase_step_o,
  output logic             commit_o,
  output ssc_word_t        ref_divider_o,
  output ssc_word_t        function_control_o,
  output ssc_word_t        timing_clock_control_o,
  output ssc_word_t        deviation_control_o,
  output ssc_word_t        ramp_step_word_o,
  output ssc_word_t        ramp_delay_control_o
);
  // Link-domain state: only the input shift register runs on the link clock.
  typedef struct packed {
    ssc_word_t sh;
  } ssc_lnk_s;

  // System-domain state: strobe synchroniser, staged words and committed outputs.
  // Registers 1 and 2 are held here until a register 0 write releases them.
  typedef struct packed {
    logic [2:0]  le_sync;
    ssc_word_t   stage1;
    ssc_word_t   stage2;
    logic        ramp_on;
    logic [3:0]  mon;
    logic [11:0] int_v;
    logic [24:0] subunit_numerator;
    logic        ph_en;
    logic [11:0] ph;
    logic        ph_step;
    logic        commit;
    ssc_word_t   r2;
    ssc_word_t   r3;
    ssc_word_t   r4;
    ssc_word_t   r5;
    ssc_word_t   r6;
    ssc_word_t   r7;
  } ssc_sys_s;

  ssc_lnk_s    l, next_l;
  ssc_sys_s    s, next_s;

  // Strobe rise as seen after the two synchroniser stages.
  logic        strobe_rise;

  // Fraction built from the word in the shift register and the staged low part.
  logic [24:0] subunit_numerator_new;

  // Select decode used for every latch.
  function automatic logic sel_is(input ssc_word_t w, input ssc_sel_t code);
    sel_is = (w[`SSC_SEL_W-1:0] == code);
  endfunction

  // High part weighted by two to the thirteenth, plus the low part.
  // Written as a sum rather than a concatenation so that the weight stays visible.
  function automatic logic [24:0] subunit_numerator_join(input ssc_word_t w0, input ssc_word_t w1);
    logic [24:0] hi;
    logic [24:0] lo;
    hi = 25'(w0[`SSC_R0_FMSB_HI:`SSC_R0_FMSB_LO]);
    lo = 25'(w1[`SSC_R1_FLSB_HI:`SSC_R1_FLSB_LO]);
    subunit_numerator_join = 25'(lo + (hi << `SSC_FLSB_W));
  endfunction

  // The shift register takes a bit on every rising link edge, whatever the strobe
  // does. The strobe is not read on the link clock at all: the host keeps the link
  // clock still from the last data edge until the strobe has fallen, so the word
  // stands untouched while the system side takes it.
  // Limitation: a link clock that ran on during the strobe would shift the word away
  // before it is taken; the host must respect this, and the checker watches for it.
  // Trade-off: no strobe logic on the link clock means no latch can be missed when
  // the link clock stops right after the last bit, which is what hosts usually do.
  always_comb begin
    next_l    = l;
    next_l.sh = {l.sh[30:0], link.ser_data};
  end

  // Link domain register; the link clock stops between frames, which is harmless.
  always_ff @(posedge link.ser_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // The strobe is a pin from another domain, so it passes two flops before any
  // logic reads it; the third stage only remembers the previous level for the edge.
  // The shift register is stable from the strobe rise onward, so reading its word
  // here, qualified by the synchronised edge, is a safe crossing.
  assign strobe_rise = s.le_sync[1] & ~s.le_sync[2];
  assign subunit_numerator_new    = subunit_numerator_join(l.sh, s.stage1);

  // Latch selection and double-buffered commit on the system clock.
  always_comb begin
    next_s         = s;
    next_s.le_sync = {s.le_sync[1:0], link.load_strobe};
    next_s.commit  = 1'b0;
    next_s.ph_step = 1'b0;
    if (strobe_rise) begin
      if (sel_is(l.sh, `SSC_SEL_R0)) begin
        // A register 0 write releases everything that was staged.
        next_s.commit  = 1'b1;
        next_s.ramp_on = l.sh[`SSC_R0_RAMP_ON];
        next_s.mon     = l.sh[`SSC_R0_MON_HI:`SSC_R0_MON_LO];
        next_s.int_v   = l.sh[`SSC_R0_INT_HI:`SSC_R0_INT_LO];
        // Integer and whole fraction change in one cycle, never half old.
        next_s.subunit_numerator    = subunit_numerator_new;
        next_s.ph_en   = s.stage1[`SSC_R1_PH_EN];
        next_s.ph      = s.stage1[`SSC_R1_PH_HI:`SSC_R1_PH_LO];
        // Phase step fires only here, never at the register 1 write.
        next_s.ph_step = s.stage1[`SSC_R1_PH_EN];
        next_s.r2      = s.stage2;
      end
      // Register 1 is only staged; it is applied at the next register 0 write.
      if (sel_is(l.sh, `SSC_SEL_R1)) begin
        next_s.stage1 = l.sh;
      end
      // Register 2 is staged the same way.
      if (sel_is(l.sh, `SSC_SEL_R2)) begin
        next_s.stage2 = l.sh;
      end
      // Registers 3 to 7 take effect as soon as they are written.
      if (sel_is(l.sh, `SSC_SEL_R3)) begin
        next_s.r3 = l.sh;
      end
      if (sel_is(l.sh, `SSC_SEL_R4)) begin
        next_s.r4 = l.sh;
      end
      if (sel_is(l.sh, `SSC_SEL_R5)) begin
        next_s.r5 = l.sh;
      end
      if (sel_is(l.sh, `SSC_SEL_R6)) begin
        next_s.r6 = l.sh;
      end
      if (sel_is(l.sh, `SSC_SEL_R7)) begin
        next_s.r7 = l.sh;
      end
    end
  end

  // System domain register, frozen while the enable is low.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

  assign ramp_on_o               = s.ramp_on;
  assign output_monitor_select_o = s.mon;
  assign int_value_o             = s.int_v;
  assign subunit_numerator_o     = s.subunit_numerator;
  assign phase_adjust_on_o       = s.ph_en;
  assign phase_word_o            = s.ph;
  assign phase_step_o            = s.ph_step;
  assign commit_o                = s.commit;
  assign ref_divider_o           = s.r2;
  assign function_control_o      = s.r3;
  assign timing_clock_control_o  = s.r4;
  assign deviation_control_o     = s.r5;
  assign ramp_step_word_o        = s.r6;
  assign ramp_delay_control_o    = s.r7;
endmodule

// ==== verif/ssc_link_checker.sv ====
// Checker for the host-driven serial link.
`timescale 1ns/1ps
module ssc_link_checker (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe
);
  logic [5:0]  cnt;
  logic [31:0] sh;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // Rebuild each frame; the strobe closes it, so the count restarts there.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 6'h00;
      sh  <= 32'h0000_0000;
    end else if (load_strobe) begin
      cnt <= 6'h00;
    end else if ($rose(ser_clk)) begin
      cnt <= cnt + 6'h01;
      sh  <= {sh[30:0], ser_data};
    end
  end

  bit_count_a: assert property ($rose(load_strobe) |-> cnt == 6'h20)
    else $error("strobe not after 32 bits");
  data_hold_a: assert property ($rose(ser_clk) |-> $stable(ser_data))
    else $error("data moved at clock rise");
  clk_quiet_a: assert property (load_strobe |-> !ser_clk)
    else $error("link clock runs in strobe");
  clk_half_a: assert property ($rose(ser_clk) |-> ser_clk[*4] ##1 !ser_clk)
    else $error("link clock half period");
  r1_resv_a: assert property ($rose(load_strobe) && sh[2:0] == 3'h1 |-> sh[31:29] == 3'h0)
    else $error("reserved bits set");
  r3_resv_a: assert property ($rose(load_strobe) && sh[2:0] == 3'h3 |->
    sh[17] && sh[31:25] == 7'h00 && sh[20:18] == 3'h0) else $error("reserved bits set");
  r4_resv_a: assert property ($rose(load_strobe) && sh[2:0] == 3'h4 |-> sh[5:3] == 3'h0)
    else $error("reserved bits set");
  r5_resv_a: assert property ($rose(load_strobe) && sh[2:0] == 3'h5 |->
    sh[31:30] == 2'h0 && !sh[28] && sh[25:24] == 2'h0) else $error("reserved bits set");
  r6_resv_a: assert property ($rose(load_strobe) && sh[2:0] == 3'h6 |-> sh[31:24] == 8'h00)
    else $error("reserved bits set");
  r7_resv_a: assert property ($rose(load_strobe) && sh[2:0] == 3'h7 |->
    sh[31:23] == 9'h000 && !sh[18]) else $error("reserved bits set");
  cover property ($rose(load_strobe) && sh[2:0] == 3'h0);
  cover property ($rose(load_strobe) && sh[2:0] == 3'h1);
  cover property ($rose(load_strobe) && sh[2:0] == 3'h7);
endmodule

// ==== verif/synth_serial_config_registers_tb.sv ====
// Bench: host to device on one link, a bench-driven link into a second device.
`timescale 1ns/1ps
module synth_serial_config_registers_tb;
  import ssc_pkg::*;
  logic        clk_sys_i, nrst_i, req, lk_run, busy, done, ramp, padj, pstep, com;
  logic [3:0]  mon;
  logic [11:0] intv, phw;
  logic [24:0] num;
  ssc_word_t   word, cap, rnd, refd, r3, r4, r5, r6, r7;
  ssc_word_t   a0 = '0, a1 = '0, a2 = '0, s1 = '0, s2 = '0;
  ssc_word_t   rg [8] = '{default: '0};
  ssc_word_t   hw;
  ssc_word_t   hreg [3:7];
  logic [11:0] hint;
  int          failures = 0, n_tests = 0, ncom = 0, nph = 0, gcom = 0, gph = 0, i;
  ssc_link_if lk1 ();
  ssc_link_if lk2 ();
  ssc_host ssc_host_inst (.clk_sys_i, .nrst_i, .clk_en_i(1'b1), .req_i(req), .word_i(word),
    .busy_o(busy), .done_o(done), .link(lk1.host));
  ssc_dev ssc_dev_inst (.clk_sys_i, .nrst_i, .clk_en_i(1'b1), .link(lk1.device), .ramp_on_o(),
    .output_monitor_select_o(), .int_value_o(hint), .subunit_numerator_o(),
    .phase_adjust_on_o(), .phase_word_o(), .phase_step_o(), .commit_o(), .ref_divider_o(),
    .function_control_o(hreg[3]), .timing_clock_control_o(hreg[4]),
    .deviation_control_o(hreg[5]), .ramp_step_word_o(hreg[6]),
    .ramp_delay_control_o(hreg[7]));
  ssc_dev ssc_dev_inst_b (.clk_sys_i, .nrst_i, .clk_en_i(1'b1), .link(lk2.device),
    .ramp_on_o(ramp), .output_monitor_select_o(mon), .int_value_o(intv),
    .subunit_numerator_o(num), .phase_adjust_on_o(padj), .phase_word_o(phw),
    .phase_step_o(pstep), .commit_o(com), .ref_divider_o(refd), .function_control_o(r3),
    .timing_clock_control_o(r4), .deviation_control_o(r5), .ramp_step_word_o(r6),
    .ramp_delay_control_o(r7));
  ssc_link_checker ssc_link_checker_inst (.clk_sys_i, .nrst_i, .ser_clk(lk1.ser_clk),
    .ser_data(lk1.ser_data), .load_strobe(lk1.load_strobe));

  // System clock, then a link clock that only runs within frames.
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    lk2.ser_clk = 1'b0;
    #3;
    forever #80 lk2.ser_clk = lk_run ? ~lk2.ser_clk : 1'b0;
  end

  // Count one-cycle pulses and capture what the host puts on the wire.
  always @(posedge clk_sys_i) begin
    gcom <= gcom + int'(com);
    gph  <= gph + int'(pstep);
  end
  always @(posedge lk1.ser_clk) if (!lk1.load_strobe) cap <= {cap[30:0], lk1.ser_data};

  function automatic ssc_word_t xs(ssc_word_t s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Host-side words keep reserved bits at the levels the device expects.
  function automatic ssc_word_t legal(ssc_word_t v, ssc_sel_t s);
    v[2:0] = s;
    case (s)
      3'h1: begin v[31:29] = 3'h0; if (!v[28]) v[14:3] = 12'h000; end
      3'h3: begin v[31:25] = 7'h00; v[20:17] = 4'h1; end
      3'h4: v[5:3] = 3'h0;
      3'h5: begin v[31:30] = 2'h0; v[28] = 1'b0; v[25:24] = 2'h0; end
      3'h6: v[31:24] = 8'h00;
      3'h7: begin v[31:23] = 9'h000; v[18] = 1'b0; end
      default: ;
    endcase
    return v;
  endfunction

  function automatic logic [24:0] subunit_numerator_of(ssc_word_t r0, ssc_word_t r1);
    return 25'(r1[27:15]) + 25'(r0[14:3]) * 25'h2000;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic host_send(input ssc_word_t v);
    @(posedge clk_sys_i);
    req  <= 1'b1;
    word <= v;
    do @(negedge clk_sys_i); while (busy !== 1'b1);
    @(posedge clk_sys_i);
    req <= 1'b0;
    do @(negedge clk_sys_i); while (done !== 1'b1);
    repeat (2) @(negedge clk_sys_i);
    check(cap, v);
  endtask

  // Shift MSB first, stop the link clock, then pulse the strobe on the system clock.
  task automatic dev_send(input ssc_word_t v);
    lk_run = 1'b1;
    for (int b = 31; b >= 0; b--) begin
      @(negedge lk2.ser_clk);
      lk2.ser_data <= v[b];
    end
    @(negedge lk2.ser_clk);
    lk_run = 1'b0;
    @(posedge clk_sys_i);
    lk2.load_strobe <= 1'b1;
    lk2.ser_data    <= ~v[0];
    repeat (6) @(posedge clk_sys_i);
    lk2.load_strobe <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    case (v[2:0])
      3'h0: begin a0 = v; a1 = s1; a2 = s2; ncom++; nph += int'(s1[28]); end
      3'h1: s1 = v;
      3'h2: s2 = v;
      default: rg[v[2:0]] = v;
    endcase
    @(negedge clk_sys_i);
    check(ramp, a0[31]);
    check(mon, a0[30:27]);
    check(intv, a0[26:15]);
    check(num, subunit_numerator_of(a0, a1));
    check(padj, a1[28]);
    check(phw, a1[14:3]);
    check(gph, nph);
    check(gcom, ncom);
    check(refd, a2);
    check(r3, rg[3]);
    check(r4, rg[4]);
    check(r5, rg[5]);
    check(r6, rg[6]);
    check(r7, rg[7]);
  endtask

  // Reset, every select through the host, staged corners, then random words.
  initial begin
    nrst_i = 1'b0;
    req = 1'b0;
    word = '0;
    lk_run = 1'b0;
    lk2.ser_data = 1'b0;
    lk2.load_strobe = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rnd = 32'h0000_0047;
    for (i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      hw = legal(rnd, 3'(i));
      host_send(hw);
      if (i == 0) check(32'(hint), 32'(hw[26:15]));
      if (i >= 3) check(hreg[i], hw);
    end
    dev_send(legal(32'hffff_ffff, 3'h1));
    dev_send(legal(32'h5a5a_a5a5, 3'h2));
    dev_send(legal(32'hffff_ffff, 3'h0));
    dev_send(legal(32'h0000_0000, 3'h1));
    dev_send(legal(32'h0000_0000, 3'h0));
    for (i = 0; i < 40; i++) begin
      rnd = xs(rnd);
      dev_send(legal(rnd, rnd[6:4]));
    end
    conclude();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #600_000;
    failures++;
    conclude();
  end
endmodule
